/* File: handoff_pkg.sv */
// Shared constants for the absolute position handoff between a servo amplifier and its controller.
// Assumes both ends run on one 100 MHz clock with a synchronous active-high reset.
package handoff_pkg;

  // ---------------------------------------------------------------------------
  // Serial characters
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CMD_HI_CHAR    = 8'h30;
  localparam logic [7:0] CMD_LO_CHAR    = 8'h32;
  localparam logic [7:0] DATA_HI_CHAR   = 8'h39;
  localparam logic [7:0] DATA_LO_CHAR   = 8'h31;
  localparam logic [7:0] STATUS_OK_CHAR = 8'h41;
  localparam logic [7:0] ERR_CMD_CHAR   = 8'h43;
  localparam logic [7:0] STATION_CHAR   = 8'h30;

  localparam logic [2:0] REQ_LAST_IDX   = 3'h4;
  localparam logic [3:0] REPLY_LAST_IDX = 4'h9;
  localparam logic [3:0] REPLY_LEN_OK   = 4'hA;
  localparam logic [3:0] REPLY_LEN_ERR  = 4'h2;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ           = 100_000_000;
  localparam int unsigned CYC_PER_MS       = CLK_HZ / 1000;
  localparam int unsigned SON_TO_BASE_MS   = 95;
  localparam int unsigned STOP_TO_BASE_MS  = 210;
  localparam int unsigned BASE_TO_READY_MS = 5;
  localparam int unsigned REPLY_TIMEOUT_MS = 10;
  localparam int unsigned SON_TO_BASE_CYC   = SON_TO_BASE_MS * CYC_PER_MS;
  localparam int unsigned STOP_TO_BASE_CYC  = STOP_TO_BASE_MS * CYC_PER_MS;
  localparam int unsigned BASE_TO_READY_CYC = BASE_TO_READY_MS * CYC_PER_MS;
  localparam int unsigned REPLY_TIMEOUT_CYC = REPLY_TIMEOUT_MS * CYC_PER_MS;
  localparam int unsigned MAX_RETRY_DEF     = 3;

  localparam logic [31:0] POS_RESET = 32'h0000_0000;

endpackage

/* File: handoff_if.sv */
// Link between the servo amplifier end and the positioning controller end.
// Assumes both ends share one clock; every signal is a plain same-clock level or strobe.
`timescale 1ns/100ps
interface handoff_if;
  logic       servo_enable_input;
  logic       drive_ready;
  logic       fault_indicator;
  logic       req_valid;
  logic [7:0] req_data;
  logic       rep_valid;
  logic [7:0] rep_data;
  logic       cmd_pulse;
  logic       cmd_dir;

  modport dev (
    input  servo_enable_input,
    output drive_ready,
    output fault_indicator,
    input  req_valid,
    input  req_data,
    output rep_valid,
    output rep_data,
    input  cmd_pulse,
    input  cmd_dir
  );

  modport ctl (
    output servo_enable_input,
    input  drive_ready,
    input  fault_indicator,
    output req_valid,
    output req_data,
    input  rep_valid,
    input  rep_data,
    output cmd_pulse,
    output cmd_dir
  );
endinterface

/* File: absolute_position_handoff_dev.sv */
// Servo amplifier end: power sequencing, position read reply and position command register.
// Assumes the controller end on the same clock; forced stop and alarm come from pins.
`timescale 1ns/100ps
module absolute_position_handoff_dev #(
  parameter int unsigned SON_TO_BASE_CYC   = handoff_pkg::SON_TO_BASE_CYC,
  parameter int unsigned STOP_TO_BASE_CYC  = handoff_pkg::STOP_TO_BASE_CYC,
  parameter int unsigned BASE_TO_READY_CYC = handoff_pkg::BASE_TO_READY_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  handoff_if.dev           link,
  input  wire logic        forced_stop_i,
  input  wire logic        alarm_i,
  input  wire logic [31:0] abs_position_i,
  output logic             base_on_o,
  output logic [31:0]      position_cmd_o
);

  typedef enum {PWR_OFF, PWR_WAIT_BASE, PWR_WAIT_READY, PWR_READY} pwr_state_t;

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction

  function automatic logic [7:0] req_char(input logic [2:0] idx);
    case (idx)
      3'h1:    req_char = handoff_pkg::CMD_HI_CHAR;
      3'h2:    req_char = handoff_pkg::CMD_LO_CHAR;
      3'h3:    req_char = handoff_pkg::DATA_HI_CHAR;
      default: req_char = handoff_pkg::DATA_LO_CHAR;
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic       stop_s;
  logic       alarm_s;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= 2'h0;
      sync2_reg <= 2'h0;
    end else begin
      sync1_reg <= {alarm_i, forced_stop_i};
      sync2_reg <= sync1_reg;
    end
  end
  assign stop_s  = sync2_reg[0];
  assign alarm_s = sync2_reg[1];

  // ---------------------------------------------------------------------------
  // Power sequencing
  // ---------------------------------------------------------------------------
  pwr_state_t  pwr_reg,  pwr_next;
  logic [31:0] cnt_reg,  cnt_next;
  logic        base_reg, base_next;
  logic        rdy_reg,  rdy_next;
  logic        seen_reg, seen_next;
  logic        hold_off;
  logic [31:0] target;

  assign hold_off = stop_s | alarm_s | ~link.servo_enable_input;

  always_comb begin
    pwr_next  = pwr_reg;
    cnt_next  = cnt_reg + 32'h1;
    base_next = base_reg;
    rdy_next  = rdy_reg;
    seen_next = seen_reg | stop_s;
    target    = 32'h1;
    case (pwr_reg)
      PWR_OFF: begin
        cnt_next = 32'h0;
        if (!hold_off) begin
          pwr_next = PWR_WAIT_BASE;
        end
      end
      PWR_WAIT_BASE: begin
        target = seen_reg ? STOP_TO_BASE_CYC : SON_TO_BASE_CYC;
        if (cnt_reg >= target - 32'h1) begin
          base_next = 1'b1;
          cnt_next  = 32'h0;
          pwr_next  = PWR_WAIT_READY;
        end
      end
      PWR_WAIT_READY: begin
        target = seen_reg ? BASE_TO_READY_CYC : 32'h1;
        if (cnt_reg >= target - 32'h1) begin
          rdy_next  = 1'b1;
          seen_next = stop_s;
          pwr_next  = PWR_READY;
        end
      end
      PWR_READY: begin
        cnt_next = 32'h0;
      end
      default: begin
        pwr_next = PWR_OFF;
      end
    endcase
    if (hold_off) begin
      pwr_next  = PWR_OFF;
      cnt_next  = 32'h0;
      base_next = 1'b0;
      rdy_next  = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_reg  <= PWR_OFF;
      cnt_reg  <= 32'h0;
      base_reg <= 1'b0;
      rdy_reg  <= 1'b0;
      seen_reg <= 1'b1;
    end else begin
      pwr_reg  <= pwr_next;
      cnt_reg  <= cnt_next;
      base_reg <= base_next;
      rdy_reg  <= rdy_next;
      seen_reg <= seen_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Read command decode, reply and position command
  // ---------------------------------------------------------------------------
  logic [2:0]  rx_idx_reg,  rx_idx_next;
  logic        mine_reg,    mine_next;
  logic        bad_reg,     bad_next;
  logic [3:0]  tx_left_reg, tx_left_next;
  logic [3:0]  tx_pos_reg,  tx_pos_next;
  logic [7:0]  status_reg,  status_next;
  logic [31:0] shift_reg,   shift_next;
  logic        rv_reg,      rv_next;
  logic [7:0]  rd_reg,      rd_next;
  logic [31:0] pcmd_reg,    pcmd_next;
  logic        bad_now;

  always_comb begin
    rx_idx_next  = rx_idx_reg;
    mine_next    = mine_reg;
    bad_next     = bad_reg;
    tx_left_next = tx_left_reg;
    tx_pos_next  = tx_pos_reg;
    status_next  = status_reg;
    shift_next   = shift_reg;
    rv_next      = 1'b0;
    rd_next      = rd_reg;
    pcmd_next    = pcmd_reg;
    bad_now      = bad_reg | (link.req_data != req_char(rx_idx_reg));
    if (link.cmd_pulse && base_reg) begin
      pcmd_next = link.cmd_dir ? pcmd_reg - 32'h1 : pcmd_reg + 32'h1;
    end
    if (tx_left_reg != 4'h0) begin
      rv_next      = 1'b1;
      tx_left_next = tx_left_reg - 4'h1;
      tx_pos_next  = tx_pos_reg + 4'h1;
      if (tx_pos_reg == 4'h0) begin
        rd_next = handoff_pkg::STATION_CHAR;
      end else if (tx_pos_reg == 4'h1) begin
        rd_next = status_reg;
      end else begin
        rd_next    = hex_char(shift_reg[31:28]);
        shift_next = {shift_reg[27:0], 4'h0};
      end
    end
    if (link.req_valid) begin
      if (rx_idx_reg == 3'h0) begin
        mine_next   = (link.req_data == handoff_pkg::STATION_CHAR);
        bad_next    = 1'b0;
        rx_idx_next = 3'h1;
      end else if (rx_idx_reg == handoff_pkg::REQ_LAST_IDX) begin
        rx_idx_next = 3'h0;
        if (mine_reg && tx_left_reg == 4'h0) begin
          tx_pos_next = 4'h0;
          if (bad_now) begin
            status_next  = handoff_pkg::ERR_CMD_CHAR;
            tx_left_next = handoff_pkg::REPLY_LEN_ERR;
          end else begin
            status_next  = handoff_pkg::STATUS_OK_CHAR;
            tx_left_next = handoff_pkg::REPLY_LEN_OK;
            shift_next   = abs_position_i;
            pcmd_next    = abs_position_i;
          end
        end
      end else begin
        bad_next    = bad_now;
        rx_idx_next = rx_idx_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_idx_reg  <= 3'h0;
      mine_reg    <= 1'b0;
      bad_reg     <= 1'b0;
      tx_left_reg <= 4'h0;
      tx_pos_reg  <= 4'h0;
      status_reg  <= 8'h00;
      shift_reg   <= 32'h0000_0000;
      rv_reg      <= 1'b0;
      rd_reg      <= 8'h00;
      pcmd_reg    <= handoff_pkg::POS_RESET;
    end else begin
      rx_idx_reg  <= rx_idx_next;
      mine_reg    <= mine_next;
      bad_reg     <= bad_next;
      tx_left_reg <= tx_left_next;
      tx_pos_reg  <= tx_pos_next;
      status_reg  <= status_next;
      shift_reg   <= shift_next;
      rv_reg      <= rv_next;
      rd_reg      <= rd_next;
      pcmd_reg    <= pcmd_next;
    end
  end

  assign link.drive_ready     = rdy_reg;
  assign link.fault_indicator = alarm_s;
  assign link.rep_valid       = rv_reg;
  assign link.rep_data        = rd_reg;
  assign base_on_o            = base_reg;
  assign position_cmd_o       = pcmd_reg;

endmodule

/* File: absolute_position_handoff_ctl.sv */
// Positioning controller end: servo enable, position acquisition with retries, pulse gating.
// Assumes the amplifier end on the same clock; user inputs are same-clock logic levels.
`timescale 1ns/100ps
module absolute_position_handoff_ctl #(
  parameter int unsigned REPLY_TIMEOUT_CYC = handoff_pkg::REPLY_TIMEOUT_CYC,
  parameter int unsigned MAX_RETRY         = handoff_pkg::MAX_RETRY_DEF
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  handoff_if.ctl           link,
  input  wire logic        servo_request_i,
  input  wire logic        move_req_i,
  input  wire logic        move_dir_i,
  output logic [31:0]      abs_position_o,
  output logic             position_valid_o,
  output logic             transfer_fail_o,
  output logic             fault_hold_o
);

  typedef enum {C_IDLE, C_SEND, C_WAIT, C_DONE, C_FAIL} ctl_state_t;

  // ---------------------------------------------------------------------------
  // Character helpers
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] frame_char(input logic [2:0] idx);
    case (idx)
      3'h0:    frame_char = handoff_pkg::STATION_CHAR;
      3'h1:    frame_char = handoff_pkg::CMD_HI_CHAR;
      3'h2:    frame_char = handoff_pkg::CMD_LO_CHAR;
      3'h3:    frame_char = handoff_pkg::DATA_HI_CHAR;
      default: frame_char = handoff_pkg::DATA_LO_CHAR;
    endcase
  endfunction

  function automatic logic is_hex(input logic [7:0] c);
    is_hex = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
  endfunction

  function automatic logic [3:0] hex_val(input logic [7:0] c);
    logic [7:0] v;
    v = (c <= 8'h39) ? (c - 8'h30) : (c - 8'h37);
    hex_val = v[3:0];
  endfunction

  // ---------------------------------------------------------------------------
  // Servo enable and fault hold
  // ---------------------------------------------------------------------------
  // A fault drops servo enable and keeps it low until the fault has cleared
  // and the user has withdrawn the request, so a new enable restarts the
  // whole power-on sequence including a fresh position read.
  logic hold_reg, hold_next;
  logic son_reg,  son_next;

  always_comb begin
    hold_next = hold_reg;
    if (link.fault_indicator) begin
      hold_next = 1'b1;
    end else if (!servo_request_i) begin
      hold_next = 1'b0;
    end
    son_next = servo_request_i & ~hold_next & ~link.fault_indicator;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_reg <= 1'b0;
      son_reg  <= 1'b0;
    end else begin
      hold_reg <= hold_next;
      son_reg  <= son_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Position acquisition
  // ---------------------------------------------------------------------------
  ctl_state_t  st_reg,    st_next;
  logic        rdy_q_reg, rdy_q_next;
  logic [2:0]  tx_idx_reg, tx_idx_next;
  logic [3:0]  rx_idx_reg, rx_idx_next;
  logic [31:0] timer_reg, timer_next;
  logic [31:0] retry_reg, retry_next;
  logic [31:0] acc_reg,   acc_next;
  logic [31:0] pos_reg,   pos_next;
  logic        valid_reg, valid_next;
  logic        fail_reg,  fail_next;
  logic        rqv_reg,   rqv_next;
  logic [7:0]  rqd_reg,   rqd_next;
  logic        rx_bad;
  logic        attempt_failed;

  always_comb begin
    st_next        = st_reg;
    rdy_q_next     = link.drive_ready;
    tx_idx_next    = tx_idx_reg;
    rx_idx_next    = rx_idx_reg;
    timer_next     = timer_reg;
    retry_next     = retry_reg;
    acc_next       = acc_reg;
    pos_next       = pos_reg;
    valid_next     = valid_reg;
    fail_next      = fail_reg;
    rqv_next       = 1'b0;
    rqd_next       = rqd_reg;
    rx_bad         = 1'b0;
    attempt_failed = 1'b0;
    case (st_reg)
      C_IDLE: begin
        if (link.drive_ready && !rdy_q_reg) begin
          st_next     = C_SEND;
          tx_idx_next = 3'h0;
          retry_next  = 32'h0;
        end
      end
      C_SEND: begin
        rqv_next    = 1'b1;
        rqd_next    = frame_char(tx_idx_reg);
        tx_idx_next = tx_idx_reg + 3'h1;
        if (tx_idx_reg == handoff_pkg::REQ_LAST_IDX) begin
          st_next     = C_WAIT;
          timer_next  = 32'h0;
          rx_idx_next = 4'h0;
          acc_next    = 32'h0;
        end
      end
      C_WAIT: begin
        timer_next = timer_reg + 32'h1;
        if (link.rep_valid) begin
          rx_idx_next = rx_idx_reg + 4'h1;
          if (rx_idx_reg == 4'h0) begin
            rx_bad = (link.rep_data != handoff_pkg::STATION_CHAR);
          end else if (rx_idx_reg == 4'h1) begin
            rx_bad = (link.rep_data != handoff_pkg::STATUS_OK_CHAR);
          end else begin
            rx_bad   = ~is_hex(link.rep_data);
            acc_next = {acc_reg[27:0], hex_val(link.rep_data)};
            if (!rx_bad && rx_idx_reg == handoff_pkg::REPLY_LAST_IDX) begin
              pos_next   = {acc_reg[27:0], hex_val(link.rep_data)};
              valid_next = 1'b1;
              st_next    = C_DONE;
            end
          end
        end
        if (rx_bad || timer_reg >= REPLY_TIMEOUT_CYC - 32'h1) begin
          attempt_failed = 1'b1;
        end
        if (attempt_failed) begin
          if (retry_reg >= MAX_RETRY) begin
            st_next   = C_FAIL;
            fail_next = 1'b1;
          end else begin
            retry_next  = retry_reg + 32'h1;
            tx_idx_next = 3'h0;
            st_next     = C_SEND;
          end
        end
      end
      C_DONE: begin
        st_next = C_DONE;
      end
      C_FAIL: begin
        st_next = C_FAIL;
      end
      default: begin
        st_next = C_IDLE;
      end
    endcase
    if (!link.drive_ready) begin
      st_next    = C_IDLE;
      valid_next = 1'b0;
      fail_next  = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg     <= C_IDLE;
      rdy_q_reg  <= 1'b0;
      tx_idx_reg <= 3'h0;
      rx_idx_reg <= 4'h0;
      timer_reg  <= 32'h0;
      retry_reg  <= 32'h0;
      acc_reg    <= 32'h0;
      pos_reg    <= handoff_pkg::POS_RESET;
      valid_reg  <= 1'b0;
      fail_reg   <= 1'b0;
      rqv_reg    <= 1'b0;
      rqd_reg    <= 8'h00;
    end else begin
      st_reg     <= st_next;
      rdy_q_reg  <= rdy_q_next;
      tx_idx_reg <= tx_idx_next;
      rx_idx_reg <= rx_idx_next;
      timer_reg  <= timer_next;
      retry_reg  <= retry_next;
      acc_reg    <= acc_next;
      pos_reg    <= pos_next;
      valid_reg  <= valid_next;
      fail_reg   <= fail_next;
      rqv_reg    <= rqv_next;
      rqd_reg    <= rqd_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Command pulse gating
  // ---------------------------------------------------------------------------
  // Pulses only leave once the amplifier is ready and its position has been
  // read back, so no motion is commanded against a stale position.
  logic pulse_reg, pulse_next;
  logic dir_reg,   dir_next;

  always_comb begin
    pulse_next = move_req_i & valid_reg & link.drive_ready;
    dir_next   = move_dir_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_reg <= 1'b0;
      dir_reg   <= 1'b0;
    end else begin
      pulse_reg <= pulse_next;
      dir_reg   <= dir_next;
    end
  end

  assign link.servo_enable_input = son_reg;
  assign link.req_valid          = rqv_reg;
  assign link.req_data           = rqd_reg;
  assign link.cmd_pulse          = pulse_reg;
  assign link.cmd_dir            = dir_reg;
  assign abs_position_o          = pos_reg;
  assign position_valid_o        = valid_reg;
  assign transfer_fail_o         = fail_reg;
  assign fault_hold_o            = hold_reg;

endmodule

/* File: handoff_props.sv */
// Checker for the link between the amplifier end and the controller end.
// Assumes one clock and a synchronous active-high reset; sees link signals only.
`timescale 1ns/100ps
module handoff_props #(
  parameter int unsigned SON_TO_BASE_CYC = 30
) (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       servo_enable_input,
  input wire logic       drive_ready,
  input wire logic       fault_indicator,
  input wire logic       req_valid,
  input wire logic [7:0] req_data,
  input wire logic       rep_valid,
  input wire logic [7:0] rep_data,
  input wire logic       cmd_pulse
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----
  // Count of cycles that servo enable has been held high.
  // ----
  logic [7:0] son_cnt_reg;
  logic [7:0] son_cnt_next;
  always_comb begin
    son_cnt_next = (son_cnt_reg == 8'hFF) ? son_cnt_reg : son_cnt_reg + 8'h01;
    if (!servo_enable_input) son_cnt_next = 8'h00;
  end
  always_ff @(posedge clk_i) begin
    son_cnt_reg <= rst_i ? 8'h00 : son_cnt_next;
  end

  sequence s_frame;
    req_valid && req_data == 8'h30 ##1 req_valid && req_data == 8'h30 ##1
    req_valid && req_data == 8'h32 ##1 req_valid && req_data == 8'h39 ##1 req_valid && req_data == 8'h31;
  endsequence
  sequence s_frame_end;
    req_valid && req_data == 8'h39 ##1 req_valid && req_data == 8'h31;
  endsequence
  sequence s_ok_reply;
    rep_valid && rep_data == 8'h30 ##1 rep_valid && rep_data == 8'h41 ##1 rep_valid [*8] ##1 !rep_valid;
  endsequence

  chk_frame_order: assert property ($rose(req_valid) |-> s_frame)
    else $error("request frame out of order");
  chk_reply_after_read: assert property (s_frame_end |-> ##2 s_ok_reply)
    else $error("position reply missing or malformed");
  chk_hex_chars: assert property (rep_valid |-> rep_data inside {[8'h30:8'h39], [8'h41:8'h46]})
    else $error("reply character not upper-case hex");
  chk_read_on_ready: assert property ($rose(drive_ready) |-> ##[1:4] $rose(req_valid))
    else $error("no position read after ready");
  chk_ready_delay: assert property ($rose(drive_ready) |-> son_cnt_reg >= SON_TO_BASE_CYC + 1)
    else $error("ready too soon after servo enable");
  chk_pulse_gate: assert property (cmd_pulse |-> $past(drive_ready))
    else $error("command pulse without ready");
  chk_fault_son_off: assert property ($rose(fault_indicator) |-> ##[0:2] !servo_enable_input)
    else $error("servo enable kept after fault");
  chk_ready_drops: assert property ($fell(servo_enable_input) |-> ##[1:3] !drive_ready)
    else $error("ready kept after servo enable drop");
endmodule

/* File: tb.sv */
// Testbench joining both ends; a second amplifier end takes bad frames from the bench.
// Assumes shortened counts: 30 cycles to base, 60 after a stop, 10 more to ready.
`timescale 1ns/100ps
module tb;
  localparam int unsigned SON_N = 30;
  logic        clk_i           = 1'b0;
  logic        rst_i           = 1'b1;
  logic        forced_stop_i   = 1'b0;
  logic        alarm_i         = 1'b0;
  logic [31:0] abs_pos         = 32'h0;
  logic        servo_request_i = 1'b0;
  logic        move_req_i      = 1'b0;
  logic        move_dir_i      = 1'b0;
  logic        base_on_o;
  logic [31:0] position_cmd_o;
  logic [31:0] abs_position_o;
  logic        position_valid_o;
  logic        transfer_fail_o;
  logic        fault_hold_o;
  int          error_cnt       = 0;
  int          compares        = 0;
  int          pulses          = 0;
  int          b;
  int          r;
  handoff_if link();
  handoff_if link2();

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (link.cmd_pulse === 1'b1) pulses <= pulses + 1;

  absolute_position_handoff_dev #(.SON_TO_BASE_CYC(SON_N), .STOP_TO_BASE_CYC(60), .BASE_TO_READY_CYC(10))
    absolute_position_handoff_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link.dev),
    .forced_stop_i(forced_stop_i), .alarm_i(alarm_i), .abs_position_i(abs_pos),
    .base_on_o(base_on_o), .position_cmd_o(position_cmd_o));
  absolute_position_handoff_dev absolute_position_handoff_dev_inst2 (.clk_i(clk_i), .rst_i(rst_i),
    .link(link2.dev), .forced_stop_i(1'b0), .alarm_i(1'b0), .abs_position_i(abs_pos),
    .base_on_o(), .position_cmd_o());
  absolute_position_handoff_ctl #(.REPLY_TIMEOUT_CYC(100)) absolute_position_handoff_ctl_inst (
    .clk_i(clk_i), .rst_i(rst_i), .link(link.ctl), .servo_request_i(servo_request_i),
    .move_req_i(move_req_i), .move_dir_i(move_dir_i), .abs_position_o(abs_position_o),
    .position_valid_o(position_valid_o), .transfer_fail_o(transfer_fail_o), .fault_hold_o(fault_hold_o));
  handoff_props #(.SON_TO_BASE_CYC(SON_N)) handoff_props_inst (.clk_i(clk_i), .rst_i(rst_i),
    .servo_enable_input(link.servo_enable_input), .drive_ready(link.drive_ready),
    .fault_indicator(link.fault_indicator), .req_valid(link.req_valid), .req_data(link.req_data),
    .rep_valid(link.rep_valid), .rep_data(link.rep_data), .cmd_pulse(link.cmd_pulse));

  // ----
  // Shared tasks.
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("errors=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Cycles from servo enable to base on, and from base on to ready.
  task automatic measure();
    while (link.servo_enable_input !== 1'b1) @(negedge clk_i);
    b = 0;
    r = 0;
    while (base_on_o !== 1'b1) begin @(negedge clk_i); b++; end
    while (link.drive_ready !== 1'b1) begin @(negedge clk_i); r++; end
  endtask

  task automatic acquire(input logic [31:0] pos);
    int n = 0;
    while (position_valid_o !== 1'b1 && n < 300) begin @(negedge clk_i); n++; end
    chk(position_valid_o, 1);
    chk(abs_position_o, pos);
    chk(position_cmd_o, pos);
    chk(transfer_fail_o, 0);
  endtask

  // ----
  // Scenarios.
  // ----
  task automatic t_power();
    @(posedge clk_i);
    abs_pos <= 32'hA5C3_1E7F;
    servo_request_i <= 1'b1;
    measure();
    chk(b, 61);
    chk(r, 10);
    acquire(32'hA5C3_1E7F);
  endtask

  task automatic t_pulses();
    int p0;
    @(negedge clk_i) p0 = pulses;
    @(posedge clk_i);
    move_req_i <= 1'b1;
    move_dir_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    move_req_i <= 1'b0;
    repeat (3) @(negedge clk_i);
    chk(pulses - p0, 3);
    chk(link.cmd_dir, 1);
    chk(position_cmd_o, 32'hA5C3_1E7C);
  endtask

  task automatic t_reenable();
    @(posedge clk_i) servo_request_i <= 1'b0;
    repeat (5) @(negedge clk_i);
    chk(link.drive_ready, 0);
    chk(position_valid_o, 0);
    @(posedge clk_i);
    abs_pos <= 32'h0123_BCDE;
    servo_request_i <= 1'b1;
    measure();
    chk(b, SON_N + 1);
    chk(r, 1);
    acquire(32'h0123_BCDE);
  endtask

  task automatic t_alarm();
    @(posedge clk_i) alarm_i <= 1'b1;
    repeat (6) @(negedge clk_i);
    chk(link.fault_indicator, 1);
    chk(link.servo_enable_input, 0);
    chk(fault_hold_o, 1);
    @(posedge clk_i) alarm_i <= 1'b0;
    repeat (6) @(negedge clk_i);
    chk(link.servo_enable_input, 0);
    @(posedge clk_i);
    servo_request_i <= 1'b0;
    abs_pos <= 32'h7F00_00C1;
    repeat (3) @(posedge clk_i);
    servo_request_i <= 1'b1;
    measure();
    chk(b, SON_N + 1);
    acquire(32'h7F00_00C1);
  endtask

  task automatic t_stop();
    @(posedge clk_i) forced_stop_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    forced_stop_i <= 1'b0;
    @(negedge clk_i);
    chk(link.drive_ready, 0);
    measure();
    chk(b, 63);
    chk(r, 10);
    acquire(32'h7F00_00C1);
  endtask

  // One corrupted character per frame, station first, then a clean frame.
  task automatic t_bad();
    logic [7:0] f [5] = '{8'h30, 8'h30, 8'h32, 8'h39, 8'h31};
    for (int i = 0; i < 6; i++) begin
      for (int k = 0; k < 5; k++) begin
        @(posedge clk_i);
        link2.req_valid <= 1'b1;
        link2.req_data <= (k == i) ? f[k] ^ 8'h01 : f[k];
      end
      @(posedge clk_i) link2.req_valid <= 1'b0;
      repeat (2) @(negedge clk_i);
      chk({link2.rep_valid, link2.rep_data}, (i == 0) ? 32'h000 : 32'h130);
      @(negedge clk_i);
      chk({link2.rep_valid, link2.rep_data}, (i == 0) ? 32'h000 : (i == 5) ? 32'h141 : 32'h143);
      repeat (10) @(negedge clk_i);
    end
  endtask

  initial begin
    link2.servo_enable_input = 1'b0;
    link2.req_valid = 1'b0;
    link2.req_data = 8'h00;
    link2.cmd_pulse = 1'b0;
    link2.cmd_dir = 1'b0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_power();
    t_pulses();
    t_reenable();
    t_alarm();
    t_stop();
    t_bad();
    complete_run();
  end

  // The tests need about 500 cycles; allow forty times that.
  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end
endmodule
